// *** core/pio_ctrl.sv ***
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module pio_ctrl
  import pio_pkg::*;
(
  input  wire logic        clk_i,      // System clock, 40 MHz.
  input  wire logic        reset_i,    // Synchronous reset, active high.
  input  wire apb_req_s    apb_i,      // APB request signals.
  output logic [31:0]      prdata_o,   // APB read data.
  output logic             pready_o,   // APB ready.
  output logic             pslverr_o,  // APB error on unmapped address.
  input  wire logic [31:0] pin_i,      // Level seen on each pin.
  output logic [31:0]      pin_o,      // Level driven onto each pin.
  output logic [31:0]      pin_oe_o,   // High while the controller drives an owned line, or the peripheral an unowned one.
  input  wire logic [31:0] periph_o_i, // Peripheral output level.
  input  wire logic [31:0] periph_oe_i,// Peripheral output enable.
  output logic [31:0]      periph_i_o, // Pin level given to peripheral, low on owned lines.
  output logic             irq_o       // Level interrupt.
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic        pready_q;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [31:0] rdata;

  // An access is taken in its first access cycle; pready is registered, so it rises one cycle later.
  assign acc = apb_i.psel & apb_i.penable & ~pready_q;
  assign wr  = acc & apb_i.pwrite;
  assign rd  = acc & ~apb_i.pwrite;

  logic [1:0]  fill_q;
  logic [31:0] owned_q;
  logic [31:0] drv_q;
  logic [31:0] lvl_q;
  logic [31:0] mask_q;
  logic [31:0] chg_q;
  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  logic [31:0] prev_q;
  logic [31:0] edge_det;

  // Ownership: take and release.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      owned_q <= RST_OWN;
    end else if (wr && apb_i.paddr == OFS_TAKE) begin
      owned_q <= owned_q | apb_i.pwdata;                // [R14]
    end else if (wr && apb_i.paddr == OFS_RELEASE) begin
      owned_q <= owned_q & ~apb_i.pwdata;               // [R15]
    end
  end

  // Driver direction; stored whoever owns the line.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drv_q <= RST_ZERO;                                // [R3]
    end else if (wr && apb_i.paddr == OFS_DRV_EN) begin
      drv_q <= drv_q | apb_i.pwdata;                    // [R2]
    end else if (wr && apb_i.paddr == OFS_DRV_DIS) begin
      drv_q <= drv_q & ~apb_i.pwdata;                   // [R1] [R2]
    end
  end

  // Programmed output level.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lvl_q <= RST_ZERO;                                // [R6]
    end else if (wr && apb_i.paddr == OFS_LVL_SET) begin
      lvl_q <= lvl_q | apb_i.pwdata;                    // [R4]
    end else if (wr && apb_i.paddr == OFS_LVL_CLR) begin
      lvl_q <= lvl_q & ~apb_i.pwdata;                   // [R5]
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_q <= RST_ZERO;                               // [R11]
    end else if (wr && apb_i.paddr == OFS_IRQ_EN) begin
      mask_q <= mask_q | apb_i.pwdata;                  // [R9]
    end else if (wr && apb_i.paddr == OFS_IRQ_DIS) begin
      mask_q <= mask_q & ~apb_i.pwdata;                 // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and change detection.

  // Two-stage synchroniser, then a previous-value stage for edges.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_q <= RST_ZERO;
      sync2_q <= RST_ZERO;
      prev_q  <= RST_ZERO;
      fill_q  <= 2'h0;
    end else begin
      sync1_q <= pin_i;                                 // [R17]
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      if (fill_q != SYNC_FILL) begin
        fill_q <= fill_q + 2'h1;
      end
    end
  end

  // Edges count only once both compared stages hold real pin levels, so a
  // pin that sits high through reset is not taken for a change.
  assign edge_det = (fill_q == SYNC_FILL) ? (sync2_q ^ prev_q) : RST_ZERO;

  // Sticky change flags: a new edge wins over the clear by read.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      chg_q <= RST_ZERO;                                // [R13]
    end else if (rd && apb_i.paddr == OFS_CHG_STAT) begin
      chg_q <= edge_det;                                // [R13] [R12]
    end else begin
      chg_q <= chg_q | edge_det;                        // [R12] [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and peripheral outputs, all registered.

  genvar n;
  generate
    for (n = 0; n < NUM_LINES; n++) begin : g_line
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          pin_o[n]      <= 1'b0;
          pin_oe_o[n]   <= 1'b0;
          periph_i_o[n] <= 1'b0;
        end else if (owned_q[n]) begin
          pin_o[n]      <= lvl_q[n];                    // [R7] [R4] [R16]
          pin_oe_o[n]   <= drv_q[n];                    // [R7]
          periph_i_o[n] <= 1'b0;                        // [R14]
        end else begin
          pin_o[n]      <= periph_o_i[n];               // [R2]
          pin_oe_o[n]   <= periph_oe_i[n];
          periph_i_o[n] <= sync2_q[n];
        end
      end
    end
  endgenerate

  // Interrupt while any unmasked change flag is set.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(chg_q & mask_q);                       // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and APB answer.

  // Read data selection by address.
  always_comb begin
    hit   = 1'b1;
    rdata = RST_ZERO;
    if (apb_i.paddr == OFS_TAKE || apb_i.paddr == OFS_RELEASE) begin
      rdata = RST_ZERO;
    end else if (apb_i.paddr == OFS_OWN) begin
      rdata = owned_q;                                  // [R15]
    end else if (apb_i.paddr == OFS_DRV_EN
                 || apb_i.paddr == OFS_DRV_DIS) begin
      rdata = RST_ZERO;
    end else if (apb_i.paddr == OFS_DRV_STAT) begin
      rdata = drv_q;                                    // [R3]
    end else if (apb_i.paddr == OFS_LVL_SET
                 || apb_i.paddr == OFS_LVL_CLR) begin
      rdata = RST_ZERO;
    end else if (apb_i.paddr == OFS_LVL_STAT) begin
      rdata = lvl_q;                                    // [R6]
    end else if (apb_i.paddr == OFS_PIN_STAT) begin
      rdata = sync2_q;                                  // [R8]
    end else if (apb_i.paddr == OFS_IRQ_EN
                 || apb_i.paddr == OFS_IRQ_DIS) begin
      rdata = RST_ZERO;
    end else if (apb_i.paddr == OFS_IRQ_MASK) begin
      rdata = mask_q;                                   // [R11]
    end else if (apb_i.paddr == OFS_CHG_STAT) begin
      rdata = chg_q;                                    // [R12]
    end else begin
      hit = 1'b0;
    end
  end

  // Registered answer: ready one cycle into the access phase.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_q  <= 1'b0;
      prdata_o  <= RST_ZERO;
      pslverr_o <= 1'b0;
    end else begin
      pready_q  <= acc;
      prdata_o  <= rd ? rdata : RST_ZERO;
      pslverr_o <= acc & ~hit;
    end
  end

  assign pready_o = pready_q;

endmodule : pio_ctrl

// *** core/pio_pkg.sv ***
// Functional notes
// R1: Ones written to output_driver_disable turn off that line's driver.
// R2: Driver writes on peripheral-owned lines are stored, pin unaffected.
// R3: output_driver_status reads one per output line, resets to zero.
// R4: output_level_set ones set stored level; pin follows if owned and output.
// R5: output_level_clear ones clear stored level; zeros have no effect.
// R6: output_level_status returns programmed level per line, resets zero.
// R7: Programmed level drives pin only while controller owns it as output.
// R8: pin_level_status always returns the actual pin level.
// R9: change_irq_enable ones enable change interrupt regardless of ownership.
// R10: change_irq_disable ones stop interrupt; changes still recorded.
// R11: change_irq_mask reads one per enabled pin, resets zero.
// R12: change_status bit sets on any pin edge, stays until read.
// R13: Reading change_status clears it; zero after reset.
// R14: controller_take_pin ones give pin to controller; peripheral input low.
// R15: controller_release_pin returns pin; ownership status reads one if owned.
// R16: Bit n maps to line n; interrupt while status and mask both set.
// R17: Pins are synchronised before edge detection, one record per edge.
package pio_pkg;

  localparam int unsigned NUM_LINES = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_TAKE     = 8'h00;
  localparam logic [7:0] OFS_RELEASE  = 8'h04;
  localparam logic [7:0] OFS_OWN      = 8'h08;
  localparam logic [7:0] OFS_DRV_EN   = 8'h10;
  localparam logic [7:0] OFS_DRV_DIS  = 8'h14;
  localparam logic [7:0] OFS_DRV_STAT = 8'h18;
  localparam logic [7:0] OFS_LVL_SET  = 8'h30;
  localparam logic [7:0] OFS_LVL_CLR  = 8'h34;
  localparam logic [7:0] OFS_LVL_STAT = 8'h38;
  localparam logic [7:0] OFS_PIN_STAT = 8'h3c;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h40;
  localparam logic [7:0] OFS_IRQ_DIS  = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFS_CHG_STAT = 8'h4c;

  // Reset values.
  localparam logic [31:0] RST_OWN  = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Cycles after reset until the previous-value stage holds a pin level.
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // APB request bundle.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage : pio_pkg

// *** verification/pio_ctrl_props.sv ***
`timescale 1ns/1ps
module pio_ctrl_props
  import pio_pkg::*;
(
  input wire logic        clk_i,      // Clock.
  input wire logic        reset_i,    // Reset.
  input wire apb_req_s    apb_i,      // Bus request.
  input wire logic [31:0] prdata_o,   // Read data.
  input wire logic        pready_o,   // Ready.
  input wire logic        pslverr_o,  // Error.
  input wire logic [31:0] pin_o,      // Pin level.
  input wire logic [31:0] pin_oe_o,   // Pin enable.
  input wire logic [31:0] periph_i_o, // Peripheral input.
  input wire logic [31:0] periph_o_i, // Peripheral level.
  input wire logic [31:0] periph_oe_i,// Peripheral enable.
  input wire logic        irq_o       // Interrupt.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // A request taken in its first access cycle, and whether it is mapped.
  wire tk = apb_i.psel & apb_i.penable & ~pready_o;
  wire wr = tk & apb_i.pwrite;
  wire mp = apb_i.paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
    8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c};
  sequence s_take;
    apb_i.psel && apb_i.penable && !pready_o;
  endsequence
  a_ready_next: assert property (s_take |=> pready_o)
    else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready long");
  a_err_map: assert property (pready_o |-> pslverr_o == !mp)
    else $error("error flag wrong");
  a_err_alone: assert property (pslverr_o |-> pready_o)
    else $error("stray error");
  a_write_rdata: assert property (pready_o && apb_i.pwrite |-> !prdata_o)
    else $error("write data nonzero");
  a_drive_cause: assert property ($changed(pin_oe_o) ||
    $changed(pin_o & pin_oe_o) |-> $past(wr, 2) || $past(reset_i, 2)
    || $past(periph_oe_i) != $past(periph_oe_i, 2)
    || $past(periph_o_i) != $past(periph_o_i, 2)) else $error("pin moved");
  a_owned_gate: assert property ((periph_i_o & pin_oe_o
    & ~$past(periph_oe_i)) == '0) else $error("peripheral sees pin");
  a_irq_drop: assert property ($fell(irq_o) |-> $past(tk, 2))
    else $error("irq dropped");
endmodule : pio_ctrl_props
bind pio_ctrl pio_ctrl_props u_pio_ctrl_props (.clk_i, .reset_i, .apb_i,
  .prdata_o, .pready_o, .pslverr_o, .pin_o, .pin_oe_o, .periph_i_o,
  .periph_o_i, .periph_oe_i, .irq_o);

// *** verification/pio_output_and_pin_change_interrupt_tb.sv ***
`timescale 1ns/1ps
module pio_output_and_pin_change_interrupt_tb;
  import pio_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1;
  apb_req_s apb_r = '0;
  logic [31:0] prdata_o, pin_o, pin_oe_o, periph_i_o, pad;
  logic [31:0] per_o = '0, per_oe = '0, ext = '0, own, oe, lvl, msk, chg, x;
  logic [31:0] r = 32'h0000c0fd; // Seed 49405.
  logic pready_o, pslverr_o, irq_o;
  logic [63:0] q, exp_q[$];
  int miscompares = 0, checks_done = 0;
  pio_ctrl u_pio_ctrl (.clk_i, .reset_i, .apb_i(apb_r), .prdata_o, .pready_o,
    .pslverr_o, .pin_i(pad), .pin_o, .pin_oe_o, .periph_o_i(per_o),
    .periph_oe_i(per_oe), .periph_i_o, .irq_o);
  pio_pins_model u_pio_pins_model (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
    .per_o_i(per_o), .per_oe_i(per_oe), .ext_i(ext), .pad_o(pad));
  // The clock toggles every half period of 25 ns.
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction : rnd
  function automatic logic [31:0] pad_f();
    x = oe & own;
    return (x & lvl) | (~x & per_oe & per_o) | (~x & ~per_oe & ext);
  endfunction : pad_f
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    apb_r <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_r.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 9);
    if (pready_o !== 1'b1) begin
      miscompares++;
      final_report();
    end
    apb_r <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m = '1);
    exp_q.push_back({m, e & m});
    apb(1'b0, a, '0);
  endtask : rd
  // Each read answer is compared with the oldest expectation queued.
  always @(posedge clk_i) begin
    if (pready_o === 1'b1) begin
      chk("err", 32'(apb_r.paddr == 8'h0c), 32'(pslverr_o));
      if (apb_r.pwrite === 1'b0) begin
        q = exp_q.pop_front();
        chk("rdata", q[31:0], prdata_o & q[63:32]);
      end
    end
  end
  // Main sequence: reset, reset values, then randomised rounds.
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    {own, oe, lvl, msk} = '0;
    rd(8'h18, '0);
    rd(8'h38, '0);
    rd(8'h48, '0);
    rd(8'h4c, '0);
    rd(8'h0c, '0);
    repeat (3) begin
      per_o <= rnd();
      per_oe <= rnd();
      x = rnd(); wr(8'h00, x); own |= x;
      x = rnd(); wr(8'h04, x); own &= ~x;
      rd(8'h08, own);
      x = rnd(); wr(8'h10, x); oe |= x;
      x = rnd(); wr(8'h14, x); oe &= ~x;
      rd(8'h18, oe);
      x = rnd(); wr(8'h30, x); lvl |= x;
      x = rnd(); wr(8'h34, x); lvl &= ~x;
      rd(8'h38, lvl);
      x = rnd(); wr(8'h40, x); msk |= x;
      x = rnd(); wr(8'h44, x); msk &= ~x;
      rd(8'h48, msk);
      repeat (4) @(posedge clk_i);
      chk("oe", (oe & own) | (per_oe & ~own), pin_oe_o);
      chk("lvl", (lvl & oe & own) | (per_o & per_oe & ~own),
          pin_o & pin_oe_o);
      chk("per", pad_f() & ~own, periph_i_o);
      rd(8'h3c, pad_f());
      rd(8'h4c, '0, '0);
      chg = pad_f();
      ext <= ext ^ rnd();
      repeat (6) @(posedge clk_i);
      chg = chg ^ pad_f();
      chk("irq", 32'(|(chg & msk)), 32'(irq_o));
      rd(8'h4c, chg);
      rd(8'h4c, '0);
      chk("irqc", '0, 32'(irq_o));
    end
    final_report();
  end
endmodule : pio_output_and_pin_change_interrupt_tb

// *** verification/pio_pins_model.sv ***
`timescale 1ns/1ps
// Resolves each pad: the controller wins, then the peripheral, else outside.
module pio_pins_model (
  input  wire logic [31:0] pin_o_i,  // Controller level.
  input  wire logic [31:0] pin_oe_i, // Controller enable.
  input  wire logic [31:0] per_o_i,  // Peripheral level.
  input  wire logic [31:0] per_oe_i, // Peripheral enable.
  input  wire logic [31:0] ext_i,    // Outside driver level.
  output logic [31:0]      pad_o     // Resolved pad level.
);
  // One driver per pad, so the level read back is always defined.
  assign pad_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & per_oe_i & per_o_i)
               | (~pin_oe_i & ~per_oe_i & ext_i);
endmodule : pio_pins_model
